// ==== bsu_cmp_flags.sv ====
// Constants of the branch and skip unit, and the flag unit that the compare instructions use.
// Assumes the flag register layout C,Z,N,V,S,H,T,I from bit 0 upward.
package bsu_pkg;
   localparam int PC_W = 16;
   localparam logic [PC_W-1:0] PC_RESET = 16'h0000;
   localparam logic [PC_W-1:0] PC_STEP = 16'h0001;
   localparam logic [PC_W-1:0] SKIP_ONE_WORD = 16'h0002;
   localparam logic [PC_W-1:0] SKIP_TWO_WORDS = 16'h0003;
   localparam int FLAG_C = 0;
   localparam int FLAG_Z = 1;
   localparam int FLAG_N = 2;
   localparam int FLAG_V = 3;
   localparam int FLAG_S = 4;
   localparam int FLAG_H = 5;
   localparam int FLAG_T = 6;
   localparam logic [7:0] FLAGS_RESET = 8'h00;
   localparam logic [1:0] CYC_ONE = 2'h1;
   localparam logic [1:0] CYC_TWO = 2'h2;
   localparam logic [1:0] CYC_THREE = 2'h3;
   localparam logic [15:0] MASK_K12 = 16'hF000;
   localparam logic [15:0] OP_REL_JUMP = 16'hC000;
   localparam logic [15:0] OP_REL_CALL = 16'hD000;
   localparam logic [15:0] MASK_FULL = 16'hFFFF;
   localparam logic [15:0] OP_PTR_JUMP = 16'h9409;
   localparam logic [15:0] OP_PTR_CALL = 16'h9509;
   localparam logic [15:0] MASK_TWO_REG = 16'hFC00;
   localparam logic [15:0] OP_EQ_SKIP = 16'h1000;
   localparam logic [15:0] OP_CMP_REGS = 16'h1400;
   localparam logic [15:0] OP_CMP_BORROW = 16'h0400;
   localparam logic [15:0] OP_CMP_CONST = 16'h3000;
   localparam logic [15:0] MASK_REG_SKIP = 16'hFE08;
   localparam logic [15:0] OP_SKIP_REG_LOW = 16'hFC00;
   localparam logic [15:0] OP_SKIP_REG_HIGH = 16'hFE00;
   localparam logic [15:0] MASK_IO_SKIP = 16'hFF00;
   localparam logic [15:0] OP_SKIP_IO_LOW = 16'h9900;
   localparam logic [15:0] OP_SKIP_IO_HIGH = 16'h9B00;
   localparam logic [15:0] MASK_BRANCH = 16'hFC00;
   localparam logic [15:0] OP_BR_FLAG_HIGH = 16'hF000;
   localparam logic [15:0] OP_BR_FLAG_LOW = 16'hF400;
   localparam logic [15:0] MASK_LONG_MEM = 16'hFC0F;
   localparam logic [15:0] OP_LONG_MEM = 16'h9000;
   localparam logic [15:0] MASK_LONG_JMP = 16'hFE0C;
   localparam logic [15:0] OP_LONG_JMP = 16'h940C;
endpackage

module bsu_cmp_flags
   import bsu_pkg::*;
(
   input wire logic [7:0] op_a,
   input wire logic [7:0] op_b,
   input wire logic use_borrow,
   input wire logic [7:0] flags_in,
   output logic [7:0] flags_out
);
   logic [8:0] diff;
   logic [7:0] r;
   logic borrow;

   always_comb begin
      borrow = use_borrow & flags_in[FLAG_C];
      diff = {1'b0, op_a} - {1'b0, op_b} - {8'h00, borrow};
      r = diff[7:0];
      flags_out = flags_in;
      flags_out[FLAG_C] = diff[8];
      flags_out[FLAG_N] = r[7];
      flags_out[FLAG_V] = (op_a[7] & ~op_b[7] & ~r[7]) | (~op_a[7] & op_b[7] & r[7]);
      flags_out[FLAG_H] = (~op_a[3] & op_b[3]) | (op_b[3] & r[3]) | (r[3] & ~op_a[3]);
      // With borrow, a zero result only keeps Z set so that multi-byte compares chain.
      flags_out[FLAG_Z] = (r == 8'h00) & (~use_borrow | flags_in[FLAG_Z]);
   end
endmodule

// ==== bsu_branch_skip_unit.sv ====
// Control-flow unit of an 8-bit core: jumps, calls, compares, skips and flag branches.
// Assumes the core presents the operands that the current instruction names in the same cycle.
import bsu_pkg::*;

// Overview of operation
// - Pointer jump loads PC from Z and takes two cycles.
// - Pointer call pushes return address, loads PC from Z, takes three cycles.
// - Equal-then-skip compares registers, flags untouched, skips next instruction when equal.
// - Compares subtract without result, update Z N V C H, one cycle.
// - Skip when selected general register bit is zero, flags untouched.
// - Skip when selected general register bit is one.
// - I/O bit skips test a bit for zero or one and skip.
// - Branch-on-flag-high adds offset plus one when selected flag is one.
// - Branch-on-flag-low adds offset plus one when flag is zero; one or two cycles.
// - Signed at-least branch taken when N xor V is zero.
// - Signed below branch taken when N xor V is one.
// - No-carry and unsigned at-least branch on carry zero; carry branch on one.
// - Unsigned at-least branch adds offset plus one when carry is zero.
// - Half-carry branches test H set or clear, no flag change.
// - Transfer-bit branches test T set or clear.
// - Overflow branches test V, one cycle untaken, two taken.
module bsu_branch_skip_unit
   import bsu_pkg::*;
(
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic instr_valid,
   input wire logic [15:0] instr,
   input wire logic [15:0] next_instr,
   input wire logic [7:0] rd_data,
   input wire logic [7:0] rr_data,
   input wire logic [7:0] io_data,
   input wire logic [15:0] z_ptr,
   input wire logic [7:0] flags_in,
   output logic ready_q,
   output logic [PC_W-1:0] pc_q,
   output logic push_q,
   output logic [PC_W-1:0] push_addr_q,
   output logic flags_we_q,
   output logic [7:0] flags_q
);
   typedef enum logic {BSU_RUN, BSU_HOLD} bsu_state_e;

   typedef struct packed {
      bsu_state_e state;
      logic [1:0] wait_cnt;
      logic ready;
      logic [PC_W-1:0] pc;
      logic push;
      logic [PC_W-1:0] push_addr;
      logic flags_we;
      logic [7:0] flags;
   } bsu_st_s;

   bsu_st_s st_q;
   bsu_st_s st_d;

   function automatic logic op_is(input logic [15:0] word, input logic [15:0] mask, input logic [15:0] val);
      op_is = (word & mask) == val;
   endfunction

   logic accept;
   logic is_relative_jump, is_relative_call, is_pointer_jump, is_pointer_call, is_equal_then_skip, is_cp, is_cpc, is_cpi;
   logic is_skip_on_reg_bit_low, is_skip_on_reg_bit_high, is_skip_on_io_bit_low, is_skip_on_io_bit_high, is_branch_on_flag_high, is_branch_on_flag_low;
   logic next_two;
   logic [7:0] live_flags;
   logic [7:0] cond_flags;
   logic [7:0] cmp_flags;
   logic [7:0] cmp_b;
   logic [PC_W-1:0] pc_inc;
   logic [PC_W-1:0] rel12;
   logic [PC_W-1:0] rel7;
   logic skip_cond;
   logic br_flag;

   assign accept = st_q.ready & instr_valid;
   assign is_relative_jump = op_is(instr, MASK_K12, OP_REL_JUMP);
   assign is_relative_call = op_is(instr, MASK_K12, OP_REL_CALL);
   assign is_pointer_jump = op_is(instr, MASK_FULL, OP_PTR_JUMP);
   assign is_pointer_call = op_is(instr, MASK_FULL, OP_PTR_CALL);
   assign is_equal_then_skip = op_is(instr, MASK_TWO_REG, OP_EQ_SKIP);
   assign is_cp = op_is(instr, MASK_TWO_REG, OP_CMP_REGS);
   assign is_cpc = op_is(instr, MASK_TWO_REG, OP_CMP_BORROW);
   assign is_cpi = op_is(instr, MASK_K12, OP_CMP_CONST);
   assign is_skip_on_reg_bit_low = op_is(instr, MASK_REG_SKIP, OP_SKIP_REG_LOW);
   assign is_skip_on_reg_bit_high = op_is(instr, MASK_REG_SKIP, OP_SKIP_REG_HIGH);
   assign is_skip_on_io_bit_low = op_is(instr, MASK_IO_SKIP, OP_SKIP_IO_LOW);
   assign is_skip_on_io_bit_high = op_is(instr, MASK_IO_SKIP, OP_SKIP_IO_HIGH);
   assign is_branch_on_flag_high = op_is(instr, MASK_BRANCH, OP_BR_FLAG_HIGH);
   assign is_branch_on_flag_low = op_is(instr, MASK_BRANCH, OP_BR_FLAG_LOW);
   // A skipped instruction is two words long when it is a long load/store or a long jump/call.
   assign next_two = op_is(next_instr, MASK_LONG_MEM, OP_LONG_MEM) | op_is(next_instr, MASK_LONG_JMP, OP_LONG_JMP);

   // Flags written by a compare in the previous cycle are forwarded to the branch that follows.
   assign live_flags = st_q.flags_we ? st_q.flags : flags_in;
   always_comb begin
      cond_flags = live_flags;
      cond_flags[FLAG_S] = live_flags[FLAG_N] ^ live_flags[FLAG_V];
   end

   assign pc_inc = st_q.pc + PC_STEP;
   assign rel12 = {{4{instr[11]}}, instr[11:0]};
   assign rel7 = {{9{instr[9]}}, instr[9:3]};
   assign cmp_b = is_cpi ? {instr[11:8], instr[3:0]} : rr_data;

   bsu_cmp_flags u_cmp (
      .op_a(rd_data),
      .op_b(cmp_b),
      .use_borrow(is_cpc),
      .flags_in(live_flags),
      .flags_out(cmp_flags)
   );

   always_comb begin
      skip_cond = 1'b0;
      if (is_equal_then_skip) begin
         skip_cond = rd_data == rr_data;
      end else if (is_skip_on_reg_bit_low) begin
         skip_cond = ~rd_data[instr[2:0]];
      end else if (is_skip_on_reg_bit_high) begin
         skip_cond = rd_data[instr[2:0]];
      end else if (is_skip_on_io_bit_low) begin
         skip_cond = ~io_data[instr[2:0]];
      end else if (is_skip_on_io_bit_high) begin
         skip_cond = io_data[instr[2:0]];
      end
      // Branch aliases on C, H, T, V and S all reduce to one flag bit and a polarity.
      br_flag = cond_flags[instr[2:0]];
   end

   always_comb begin
      st_d = st_q;
      st_d.push = 1'b0;
      st_d.flags_we = 1'b0;
      case (st_q.state)
         BSU_RUN: begin
            if (instr_valid) begin
               st_d.pc = pc_inc;
               if (is_relative_jump) begin
                  st_d.pc = pc_inc + rel12;
                  st_d.wait_cnt = CYC_TWO - CYC_ONE;
               end else if (is_relative_call) begin
                  st_d.pc = pc_inc + rel12;
                  st_d.push = 1'b1;
                  st_d.push_addr = pc_inc;
                  st_d.wait_cnt = CYC_THREE - CYC_ONE;
               end else if (is_pointer_jump) begin
                  st_d.pc = z_ptr;
                  st_d.wait_cnt = CYC_TWO - CYC_ONE;
               end else if (is_pointer_call) begin
                  st_d.pc = z_ptr;
                  st_d.push = 1'b1;
                  st_d.push_addr = pc_inc;
                  st_d.wait_cnt = CYC_THREE - CYC_ONE;
               end else if (is_cp | is_cpc | is_cpi) begin
                  st_d.flags = cmp_flags;
                  st_d.flags_we = 1'b1;
                  st_d.wait_cnt = 2'h0;
               end else if (is_equal_then_skip | is_skip_on_reg_bit_low | is_skip_on_reg_bit_high | is_skip_on_io_bit_low | is_skip_on_io_bit_high) begin
                  if (skip_cond) begin
                     st_d.pc = st_q.pc + (next_two ? SKIP_TWO_WORDS : SKIP_ONE_WORD);
                     st_d.wait_cnt = next_two ? CYC_THREE - CYC_ONE : CYC_TWO - CYC_ONE;
                  end else begin
                     st_d.wait_cnt = 2'h0;
                  end
               end else if ((is_branch_on_flag_high & br_flag) | (is_branch_on_flag_low & ~br_flag)) begin
                  st_d.pc = pc_inc + rel7;
                  st_d.wait_cnt = CYC_TWO - CYC_ONE;
               end else begin
                  st_d.wait_cnt = 2'h0;
               end
               if (st_d.wait_cnt != 2'h0) begin
                  st_d.state = BSU_HOLD;
                  st_d.ready = 1'b0;
               end
            end
         end
         BSU_HOLD: begin
            st_d.wait_cnt = st_q.wait_cnt - 2'h1;
            if (st_q.wait_cnt == 2'h1) begin
               st_d.state = BSU_RUN;
               st_d.ready = 1'b1;
            end
         end
         default: begin
            st_d.state = BSU_RUN;
            st_d.ready = 1'b1;
         end
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         st_q.state <= BSU_RUN;
         st_q.wait_cnt <= 2'h0;
         st_q.ready <= 1'b1;
         st_q.pc <= PC_RESET;
         st_q.push <= 1'b0;
         st_q.push_addr <= PC_RESET;
         st_q.flags_we <= 1'b0;
         st_q.flags <= FLAGS_RESET;
      end else begin
         st_q <= st_d;
      end
   end

   assign ready_q = st_q.ready;
   assign pc_q = st_q.pc;
   assign push_q = st_q.push;
   assign push_addr_q = st_q.push_addr;
   assign flags_we_q = st_q.flags_we;
   assign flags_q = st_q.flags;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);

   a_ptr_jump_target: assert property (accept && is_pointer_jump |=> pc_q == $past(z_ptr) && !ready_q ##1 ready_q)
      else $error("pointer jump target or length wrong");
   a_ptr_call_push: assert property (accept && is_pointer_call |=> push_q && push_addr_q == $past(pc_q) + PC_STEP
      && pc_q == $past(z_ptr) ##1 !ready_q ##1 ready_q)
      else $error("pointer call push or length wrong");
   a_eq_skip_flags: assert property (accept && is_equal_then_skip |=> !flags_we_q)
      else $error("equal skip touched flags");
   a_compare_one_cycle: assert property (accept && (is_cp || is_cpc || is_cpi) |=> flags_we_q && ready_q
      && pc_q == $past(pc_q) + PC_STEP)
      else $error("compare did not write flags in one cycle");
   a_reg_low_skip: assert property (accept && is_skip_on_reg_bit_low && !rd_data[instr[2:0]] && !next_two
      |=> pc_q == $past(pc_q) + SKIP_ONE_WORD && !flags_we_q)
      else $error("register bit low skip wrong");
   a_reg_high_skip: assert property (accept && is_skip_on_reg_bit_high && rd_data[instr[2:0]] && next_two
      |=> pc_q == $past(pc_q) + SKIP_TWO_WORDS)
      else $error("register bit high skip wrong");
   a_io_skip_none: assert property (accept && is_skip_on_io_bit_high && !io_data[instr[2:0]] |=> pc_q == $past(pc_q) + PC_STEP)
      else $error("I/O skip taken wrongly");
   a_flag_high_branch: assert property (accept && is_branch_on_flag_high && cond_flags[instr[2:0]]
      |=> pc_q == $past(pc_q) + PC_STEP + $past(rel7))
      else $error("flag high branch target wrong");
   a_flag_low_timing: assert property (accept && is_branch_on_flag_low && cond_flags[instr[2:0]] |=> ready_q)
      else $error("untaken branch stalled");
   a_signed_at_least: assert property (accept && is_branch_on_flag_low && instr[2:0] == 3'h4
      && !(live_flags[FLAG_N] ^ live_flags[FLAG_V]) |=> !ready_q ##1 ready_q)
      else $error("signed branch not taken");
   a_rel_jump_target: assert property (accept && is_relative_jump |=> pc_q == $past(pc_q) + PC_STEP + $past(rel12))
      else $error("relative jump target wrong");
   a_skip_three_cycles: assert property (accept && is_equal_then_skip && rd_data == rr_data && next_two
      |=> !ready_q [*2] ##1 ready_q)
      else $error("two word skip length wrong");

   // Further checks on the branch aliases, the call push and the untaken paths.
   a_rel_call_push: assert property (accept && is_relative_call |=> push_q && push_addr_q == $past(pc_q) + PC_STEP
      ##1 !push_q && !ready_q ##1 ready_q)
      else $error("relative call push or length wrong");
   a_ptr_jump_quiet: assert property (accept && is_pointer_jump |=> !push_q && !flags_we_q)
      else $error("pointer jump pushed or wrote flags");
   a_flag_low_taken: assert property (accept && is_branch_on_flag_low && !cond_flags[instr[2:0]]
      |=> pc_q == $past(pc_q) + PC_STEP + $past(rel7) && !ready_q)
      else $error("flag low branch target wrong");
   a_signed_below: assert property (accept && is_branch_on_flag_high && instr[2:0] == 3'h4
      && (live_flags[FLAG_N] ^ live_flags[FLAG_V]) |=> pc_q == $past(pc_q) + PC_STEP + $past(rel7))
      else $error("signed below branch target wrong");
   a_no_carry_timing: assert property (accept && is_branch_on_flag_low && instr[2:0] == 3'h0 && !live_flags[FLAG_C]
      |=> !ready_q ##1 ready_q)
      else $error("no carry branch length wrong");
   a_at_least_target: assert property (accept && is_branch_on_flag_low && instr[2:0] == 3'h0 && !live_flags[FLAG_C]
      |=> pc_q == $past(pc_q) + PC_STEP + $past(rel7))
      else $error("unsigned at least branch target wrong");
   a_half_carry_quiet: assert property (accept && (is_branch_on_flag_high || is_branch_on_flag_low) && instr[2:0] == 3'h5
      |=> !flags_we_q)
      else $error("half carry branch wrote flags");
   a_transfer_untaken: assert property (accept && is_branch_on_flag_high && instr[2:0] == 3'h6 && !live_flags[FLAG_T]
      |=> ready_q && pc_q == $past(pc_q) + PC_STEP)
      else $error("transfer bit branch taken wrongly");
   a_overflow_taken: assert property (accept && is_branch_on_flag_high && instr[2:0] == 3'h3 && live_flags[FLAG_V]
      |=> !ready_q ##1 ready_q)
      else $error("overflow branch length wrong");
   a_io_low_skip: assert property (accept && is_skip_on_io_bit_low && !io_data[instr[2:0]] && !next_two
      |=> pc_q == $past(pc_q) + SKIP_ONE_WORD && !ready_q ##1 ready_q)
      else $error("I/O bit low skip wrong");
   a_skip_untaken_fast: assert property (accept && (is_skip_on_reg_bit_low || is_skip_on_reg_bit_high) && !skip_cond
      |=> ready_q && pc_q == $past(pc_q) + PC_STEP)
      else $error("untaken skip stalled or moved wrongly");


   c_ptr_call: cover property (accept && is_pointer_call);
   c_skip_long: cover property (accept && is_skip_on_reg_bit_low && !rd_data[instr[2:0]] && next_two);
   c_compare_then_branch: cover property (accept && is_cp ##1 accept && is_branch_on_flag_high);
   c_branch_back: cover property (accept && is_branch_on_flag_low && !br_flag && instr[9]);
endmodule

// ==== tb_top.sv ====
// Self-checking bench for the branch and skip unit: jumps, calls, compares, skips and branches.
// Assumes the unit accepts on an edge with ready_q high and answers one cycle after acceptance.
module tb_top import bsu_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk = 1'b0;
   logic sys_rst;
   logic instr_valid;
   logic [15:0] instr = 16'h0000;
   logic [15:0] next_instr = 16'h0000;
   logic [7:0] rd_data = 8'h00;
   logic [7:0] rr_data = 8'h00;
   logic [7:0] io_data = 8'h00;
   logic [15:0] z_ptr = 16'h0000;
   logic [7:0] flags_in = 8'h00;
   logic ready_q, push_q, flags_we_q;
   logic [15:0] pc_q, push_addr_q, cur_pc;
   logic [7:0] flags_q;
   int fails = 0;
   int total_checks = 0;

   always #5 sys_clk = ~sys_clk;

   bsu_branch_skip_unit u_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .instr_valid(instr_valid),
      .instr(instr), .next_instr(next_instr), .rd_data(rd_data), .rr_data(rr_data), .io_data(io_data),
      .z_ptr(z_ptr), .flags_in(flags_in), .ready_q(ready_q), .pc_q(pc_q), .push_q(push_q),
      .push_addr_q(push_addr_q), .flags_we_q(flags_we_q), .flags_q(flags_q));

   task automatic chk_w(input string what, input logic [15:0] exp, input logic [15:0] got);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic chk_b(input string what, input logic exp, input logic got);
      chk_w(what, {15'h0000, exp}, {15'h0000, got});
   endtask

   task automatic final_report();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // The request stays offered while ready_q is low, so a wrongly accepted repeat would move the pc.
   task automatic exec(input logic [15:0] ins, input logic [15:0] nxt, input logic [15:0] tgt,
                       input int cyc, input logic psh, input logic we);
      int n;
      instr = ins;
      next_instr = nxt;
      instr_valid = 1'b1;
      @(posedge sys_clk);
      #1;
      n = 1;
      chk_b("push", psh, push_q);
      chk_b("flags_we", we, flags_we_q);
      if (psh) chk_w("push_addr", cur_pc + PC_STEP, push_addr_q);
      while (ready_q !== 1'b1 && n < 6) begin
         @(posedge sys_clk);
         #1;
         n++;
      end
      chk_w("pc", tgt, pc_q);
      chk_w("cycles", 16'(cyc), 16'(n));
      cur_pc = tgt;
   endtask

   task automatic t_reset();
      sys_rst = 1'b1;
      instr_valid = 1'b0;
      repeat (6) @(posedge sys_clk);
      #1;
      sys_rst = 1'b0;
      cur_pc = PC_RESET;
      chk_b("ready", 1'b1, ready_q);
      chk_b("push", 1'b0, push_q);
      chk_b("flags_we", 1'b0, flags_we_q);
      chk_w("pc", PC_RESET, pc_q);
      chk_w("push_addr", 16'h0000, push_addr_q);
      chk_w("flags", {8'h00, FLAGS_RESET}, {8'h00, flags_q});
   endtask

   task automatic t_jumps();
      z_ptr = 16'h3A5C;
      exec(OP_REL_JUMP | 16'h0010, 16'h0000, cur_pc + 16'h0011, 2, 1'b0, 1'b0);
      exec(OP_REL_JUMP | 16'h0FFE, 16'h0000, cur_pc - 16'h0001, 2, 1'b0, 1'b0);
      exec(OP_PTR_JUMP, 16'h0000, 16'h3A5C, 2, 1'b0, 1'b0);
      exec(OP_REL_CALL | 16'h0800, 16'h0000, cur_pc - 16'h07FF, 3, 1'b1, 1'b0);
      z_ptr = 16'h0123;
      exec(OP_PTR_CALL, 16'h0000, 16'h0123, 3, 1'b1, 1'b0);
      exec(16'h0000, 16'h0000, cur_pc + PC_STEP, 1, 1'b0, 1'b0);
   endtask

   task automatic skip_case(input logic [15:0] op, input logic [15:0] nxt, input logic take, input logic two);
      if (!take) exec(op, nxt, cur_pc + PC_STEP, 1, 1'b0, 1'b0);
      else if (two) exec(op, nxt, cur_pc + SKIP_TWO_WORDS, 3, 1'b0, 1'b0);
      else exec(op, nxt, cur_pc + SKIP_ONE_WORD, 2, 1'b0, 1'b0);
   endtask

   task automatic t_skips();
      rd_data = 8'h5A;
      rr_data = 8'h5A;
      skip_case(OP_EQ_SKIP | 16'h0123, 16'h0000, 1'b1, 1'b0);
      skip_case(OP_EQ_SKIP | 16'h0123, 16'h91F0, 1'b1, 1'b1);
      rr_data = 8'h5B;
      skip_case(OP_EQ_SKIP | 16'h0123, 16'h91F0, 1'b0, 1'b0);
      rd_data = 8'h7F;
      skip_case(OP_SKIP_REG_LOW | 16'h01F7, 16'h95FF, 1'b1, 1'b1);
      skip_case(OP_SKIP_REG_LOW | 16'h01F0, 16'h0000, 1'b0, 1'b0);
      skip_case(OP_SKIP_REG_HIGH | 16'h01F0, 16'h0000, 1'b1, 1'b0);
      skip_case(OP_SKIP_REG_HIGH | 16'h01F7, 16'h0000, 1'b0, 1'b0);
      io_data = 8'h01;
      skip_case(OP_SKIP_IO_LOW | 16'h00F9, 16'h0000, 1'b1, 1'b0);
      skip_case(OP_SKIP_IO_LOW | 16'h00F8, 16'h0000, 1'b0, 1'b0);
      skip_case(OP_SKIP_IO_HIGH | 16'h00F8, 16'h95FF, 1'b1, 1'b1);
      skip_case(OP_SKIP_IO_HIGH | 16'h00F9, 16'h0000, 1'b0, 1'b0);
   endtask

   function automatic logic [7:0] exp_cmp(input logic [7:0] a, b, old, input logic brw);
      logic [7:0] r, f;
      logic c;
      c = brw & old[FLAG_C];
      r = a - b - {7'h00, c};
      f = old;
      f[FLAG_C] = {1'b0, a} < ({1'b0, b} + {8'h00, c});
      f[FLAG_Z] = (r == 8'h00) & (!brw | old[FLAG_Z]);
      f[FLAG_N] = r[7];
      f[FLAG_V] = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
      f[FLAG_H] = (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]);
      return f;
   endfunction

   // Back-to-back compares see the previous result, so the expectation is chained.
   logic [7:0] last_f;
   task automatic cmp_case(input logic [15:0] op, input logic [7:0] a, input logic [7:0] b, input logic brw);
      rd_data = a;
      rr_data = (op[15:12] == 4'h3) ? ~b : b;
      last_f = exp_cmp(a, b, last_f, brw);
      exec(op, 16'h0000, cur_pc + PC_STEP, 1, 1'b0, 1'b1);
      chk_w("flags", {8'h00, last_f}, {8'h00, flags_q});
   endtask

   task automatic t_compare();
      flags_in = 8'hF0;
      last_f = 8'hF0;
      cmp_case(OP_CMP_REGS, 8'h00, 8'h01, 1'b0);
      cmp_case(OP_CMP_BORROW, 8'h05, 8'h04, 1'b1);
      cmp_case(OP_CMP_REGS, 8'h10, 8'h10, 1'b0);
      cmp_case(OP_CMP_BORROW, 8'h05, 8'h05, 1'b1);
      cmp_case(OP_CMP_REGS, 8'h80, 8'h01, 1'b0);
      cmp_case(OP_CMP_CONST | 16'h0850, 8'h7F, 8'h80, 1'b0);
      flags_in = 8'h08;
      exec(OP_BR_FLAG_LOW | 16'h001C, 16'h0000, cur_pc + 16'h0004, 2, 1'b0, 1'b0);
      exec(OP_BR_FLAG_HIGH | 16'h03FC, 16'h0000, cur_pc, 2, 1'b0, 1'b0);
   endtask

   task automatic br_case(input logic [15:0] op, input int s, input logic [6:0] k, input logic take);
      logic [15:0] w;
      w = op | {6'h00, k, 3'(s)};
      if (take) exec(w, 16'h0000, cur_pc + PC_STEP + {{9{k[6]}}, k}, 2, 1'b0, 1'b0);
      else exec(w, 16'h0000, cur_pc + PC_STEP, 1, 1'b0, 1'b0);
   endtask

   task automatic t_branch();
      logic cond;
      for (int p = 0; p < 2; p++) begin
         flags_in = (p == 0) ? 8'hA5 : 8'h53;
         for (int s = 0; s < 8; s++) begin
            cond = (s == FLAG_S) ? (flags_in[FLAG_N] ^ flags_in[FLAG_V]) : flags_in[s];
            br_case(OP_BR_FLAG_HIGH, s, 7'h40, cond);
            br_case(OP_BR_FLAG_LOW, s, 7'h3F, !cond);
         end
      end
   endtask

   initial begin
      #100_000;
      fails++;
      final_report();
   end

   initial begin
      t_reset();
      t_jumps();
      t_reset();
      t_skips();
      t_compare();
      t_branch();
      final_report();
   end
endmodule
